// ===== common/otp_lock_params.svh
`ifndef OTP_LOCK_PARAMS_SVH
`define OTP_LOCK_PARAMS_SVH
`define LOCK_READ_OPCODE    8'h2B
`define LOCK_WRITE_OPCODE   8'h2F
`define WRITE_ENABLE_CMD_OPCODE         8'h06
`define STATUS_WRITE_OPCODE 8'h01
`define OTP_ENTER_OPCODE    8'hB1
`define OTP_EXIT_OPCODE     8'hC1
`define FACTORY_BIT_POS     0
`define CUSTOMER_BIT_POS    1
`define ERASED_BYTE         8'hFF
`define CLK_FREQ_KHZ        25000
`define POWERUP_DELAY_US    200
`define POWERUP_CYCLES      ((`POWERUP_DELAY_US * `CLK_FREQ_KHZ + 999) / 1000)
`endif

// ===== common/otp_lock_pkg.sv
package otp_lock_pkg;
  typedef enum logic [2:0] {
    ph_opcode,
    ph_read_out,
    ph_write_data,
    ph_write_done,
    ph_ignore
  } phase_type;
endpackage

// ===== common/serial_link_if.sv
interface serial_link_if;
  logic       frame_start;
  logic       frame_end;
  logic       rise;
  logic       fall;
  logic       data_in;
  logic       selected;
  modport sampler (output frame_start, frame_end, rise, fall, data_in, selected);
  modport user    (input  frame_start, frame_end, rise, fall, data_in, selected);
endinterface

// ===== verilog/serial_sampler.sv
module serial_sampler (
  input  wire logic   clk,
  input  wire logic   reset_n,
  input  wire logic   sclk,
  input  wire logic   cs_n,
  input  wire logic   sdi,
  serial_link_if.sampler link
);
  logic [1:0] sclk_sync;
  logic [1:0] cs_sync;
  logic [1:0] sdi_sync;
  logic       sclk_last;
  logic       cs_last;

  // Two-stage synchronisers, then one delay stage for edge detection.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_sync <= 2'b00;
      cs_sync   <= 2'b11;
      sdi_sync  <= 2'b00;
      sclk_last <= 1'b0;
      cs_last   <= 1'b1;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk};
      cs_sync   <= {cs_sync[0], cs_n};
      sdi_sync  <= {sdi_sync[0], sdi};
      sclk_last <= sclk_sync[1];
      cs_last   <= cs_sync[1];
    end
  end

  // Edges are reported only from the second synchroniser stage.
  assign link.selected    = ~cs_sync[1];
  assign link.frame_start = cs_last & ~cs_sync[1];
  assign link.frame_end   = ~cs_last & cs_sync[1];
  assign link.rise        = sclk_sync[1] & ~sclk_last & ~cs_sync[1];
  assign link.fall        = ~sclk_sync[1] & sclk_last & ~cs_sync[1];
  assign link.data_in     = sdi_sync[1];
endmodule

// ===== verilog/otp_lock_core.sv
// Overview of operation
// - Lock register read answers anytime, even busy, repeating while clocked.
// - Bit 0 reports factory lock, fixed, host cannot change it.
// - Host sets bit 1 customer lock through lock register write.
// - After customer lock, lock bit and OTP area refuse all changes; the core holds no OTP area and guards only the lock bit.
// - In OTP mode main array access is blocked.
// - Lock register write needs no write enable latch.
// - Lock register write executes only if select rises on byte boundary.
// - After power-up the device is in standby, not deep power-down.
// - Power-on reset clears the write enable latch.
// - Delivered array is erased, every byte reads all ones.
// - In OTP mode status and lock register writes are rejected; the core decodes no status write and gates only lock register writes.
// - Enter and exit commands switch OTP mode on and off.
`include "otp_lock_params.svh"
module otp_lock_core
  import otp_lock_pkg::*;
#(
  parameter logic [7:0] LOCK_READ_OP   = `LOCK_READ_OPCODE,
  parameter logic [7:0] LOCK_WRITE_OP  = `LOCK_WRITE_OPCODE,
  parameter int         POWERUP_CYCLES = `POWERUP_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  input  wire logic factory_locked,
  input  wire logic array_busy,
  output logic      sdo,
  output logic      sdo_oe,
  output logic      write_enable_latch,
  output logic      otp_mode,
  output logic      array_access_blocked,
  output logic      customer_lock_bit,
  output logic      standby,
  output logic      powerup_ready,
  output logic [7:0] erased_fill
);
  serial_link_if link ();

  serial_sampler sampler (
    .clk     (clk),
    .reset_n (reset_n),
    .sclk    (sclk),
    .cs_n    (cs_n),
    .sdi     (sdi),
    .link    (link)
  );

  phase_type  phase;
  logic [7:0] shift_in;
  logic [2:0] bit_count;
  logic [7:0] data_byte;
  logic [7:0] out_shift;
  logic       factory_bit;
  logic       strap_taken;
  logic [1:0] factory_sync;
  logic [1:0] strap_wait;
  logic [31:0] pu_count;

  // Reserved bits always read as zero.
  function automatic logic [7:0] lock_value(input logic fac, input logic cust);
    lock_value = {6'b00_0000, cust, fac};
  endfunction

  wire [7:0] next_shift_in = {shift_in[6:0], link.data_in};
  wire       byte_done     = link.rise && bit_count == 3'd7;
  wire [7:0] lock_reg      = lock_value(factory_bit, customer_lock_bit);
  wire       is_lock_read  = next_shift_in == LOCK_READ_OP;
  wire       is_lock_write = next_shift_in == LOCK_WRITE_OP;
  wire       is_write_enable_cmd       = next_shift_in == `WRITE_ENABLE_CMD_OPCODE;
  wire       is_enter      = next_shift_in == `OTP_ENTER_OPCODE;
  wire       is_exit       = next_shift_in == `OTP_EXIT_OPCODE;
  wire       on_boundary   = bit_count == 3'd0;
  wire       write_allowed = ~otp_mode & ~customer_lock_bit;
  wire       commit_write  = link.frame_end && phase == ph_write_done
                             && on_boundary && write_allowed;

  assign erased_fill          = `ERASED_BYTE;
  assign array_access_blocked = otp_mode;
  assign standby              = ~link.selected;
  assign powerup_ready        = pu_count >= POWERUP_CYCLES;

  // The strap pin passes two flip-flops before it is used.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      factory_sync <= 2'b00;
    end else begin
      factory_sync <= {factory_sync[0], factory_locked};
    end
  end

  // Factory lock strap is captured once, after the synchroniser has filled.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      factory_bit <= 1'b0;
      strap_taken <= 1'b0;
      strap_wait  <= 2'd0;
    end else if (!strap_taken) begin
      if (strap_wait == 2'd2) begin
        factory_bit <= factory_sync[1];
        strap_taken <= 1'b1;
      end else begin
        strap_wait <= strap_wait + 2'd1;
      end
    end
  end

  // Counts the host's wait before its first command after power-up.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_count <= 32'h0000_0000;
    end else if (!powerup_ready) begin
      pu_count <= pu_count + 32'h0000_0001;
    end
  end

  // Bit counter and input shift register run on rising link edges.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_count <= 3'd0;
      shift_in  <= 8'h00;
    end else if (link.frame_start) begin
      bit_count <= 3'd0;
      shift_in  <= 8'h00;
    end else if (link.rise) begin
      bit_count <= bit_count + 3'd1;
      shift_in  <= next_shift_in;
    end
  end

  // Command phase sequencing within one frame.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase     <= ph_opcode;
      data_byte <= 8'h00;
    end else if (link.frame_start) begin
      phase <= ph_opcode;
    end else if (byte_done) begin
      case (phase)
        ph_opcode: begin
          if (is_lock_read) begin
            phase <= ph_read_out;
          end else if (is_lock_write) begin
            phase <= ph_write_data;
          end else begin
            phase <= ph_ignore;
          end
        end
        ph_write_data: begin
          data_byte <= next_shift_in;
          phase     <= ph_write_done;
        end
        ph_write_done: phase <= ph_ignore;
        ph_read_out:   phase <= ph_read_out;
        ph_ignore:     phase <= ph_ignore;
        default:       phase <= ph_ignore;
      endcase
    end
  end

  // Customer lock is one-way: only set, never cleared.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      customer_lock_bit <= 1'b0;
    end else if (commit_write && data_byte[`CUSTOMER_BIT_POS]) begin
      customer_lock_bit <= 1'b1;
    end
  end

  // Write enable latch and OTP mode, decoded at the opcode boundary.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_enable_latch <= 1'b0;
      otp_mode           <= 1'b0;
    end else if (byte_done && phase == ph_opcode) begin
      if (is_write_enable_cmd) begin
        write_enable_latch <= 1'b1;
      end
      if (is_enter) begin
        otp_mode <= 1'b1;
      end else if (is_exit) begin
        otp_mode <= 1'b0;
      end
    end
  end

  // Register value shifts out MSB first on falling edges, repeating.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_shift <= 8'h00;
      sdo       <= 1'b0;
      sdo_oe    <= 1'b0;
    end else if (!link.selected) begin
      sdo_oe <= 1'b0;
      sdo    <= 1'b0;
    end else if (link.fall && phase == ph_read_out) begin
      sdo_oe <= 1'b1;
      if (bit_count == 3'd0) begin
        sdo       <= lock_reg[7];
        out_shift <= {lock_reg[6:0], 1'b0};
      end else begin
        sdo       <= out_shift[7];
        out_shift <= {out_shift[6:0], 1'b0};
      end
    end
  end

  // array_busy is accepted but never gates the register read.
  wire unused_busy = array_busy;
endmodule

// ===== testbench/otp_lock_core_monitor.sv
module otp_lock_core_monitor (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       sdo_oe,
  input wire logic       write_enable_latch,
  input wire logic       otp_mode,
  input wire logic       array_access_blocked,
  input wire logic       customer_lock_bit,
  input wire logic       standby,
  input wire logic       powerup_ready,
  input wire logic [7:0] erased_fill
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Each property checks an output against the pins, another output, a constant or its own past value.
  property p_block; array_access_blocked == otp_mode; endproperty
  a_block: assert property (p_block) else $error("array block differs from otp mode");
  property p_fill; erased_fill == 8'hFF; endproperty
  a_fill: assert property (p_fill) else $error("erased fill not all ones");
  property p_lockfall; !$fell(customer_lock_bit); endproperty
  a_lockfall: assert property (p_lockfall) else $error("customer lock cleared");
  property p_lockcs; $rose(customer_lock_bit) |-> cs_n && $past(cs_n); endproperty
  a_lockcs: assert property (p_lockcs) else $error("lock set inside a frame");
  property p_lockotp; $rose(customer_lock_bit) |-> !otp_mode && !$past(otp_mode); endproperty
  a_lockotp: assert property (p_lockotp) else $error("lock set in otp mode");
  property p_standby; cs_n [*4] |-> standby; endproperty
  a_standby: assert property (p_standby) else $error("no standby while deselected");
  property p_oe; cs_n [*6] |-> !sdo_oe; endproperty
  a_oe: assert property (p_oe) else $error("output driven while deselected");
  property p_rstwel; $rose(reset_n) |-> !write_enable_latch; endproperty
  a_rstwel: assert property (p_rstwel) else $error("latch set after reset");
  property p_ready; $rose(reset_n) |-> !powerup_ready ##[1:1000] powerup_ready; endproperty
  a_ready: assert property (p_ready) else $error("power-up delay wrong");
  c_lock: cover property ($rose(customer_lock_bit));
  c_otp: cover property ($rose(otp_mode));
  c_read: cover property (sdo_oe && !cs_n);
endmodule
bind otp_lock_core otp_lock_core_monitor otp_lock_core_monitor_inst (.*);

// ===== testbench/spi_host_model.sv
module spi_host_model (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  // The link idles deselected with a still clock.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Sends the top n bits of v and gathers sdo at every rising link edge.
  task automatic xfer(input logic [23:0] v, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      sdi <= v[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rd = {rd[6:0], sdo};
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ===== testbench/test_flash_otp_lock_and_poweron.sv
module test_flash_otp_lock_and_poweron;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       reset_n;
  logic       factory_locked;
  logic       array_busy;
  wire        sclk, cs_n, sdi, sdo, sdo_oe, write_enable_latch, otp_mode;
  wire        array_access_blocked, customer_lock_bit, standby, powerup_ready;
  wire  [7:0] erased_fill;
  logic [7:0] rd;
  logic [7:0] d;
  bit         m_lock;
  bit         m_fac;
  int         num_errors = 0;
  int         total_checks = 0;
  otp_lock_core #(.POWERUP_CYCLES(10)) otp_lock_core_inst (
    .clk                  (clk),
    .reset_n              (reset_n),
    .sclk                 (sclk),
    .cs_n                 (cs_n),
    .sdi                  (sdi),
    .factory_locked       (factory_locked),
    .array_busy           (array_busy),
    .sdo                  (sdo),
    .sdo_oe               (sdo_oe),
    .write_enable_latch   (write_enable_latch),
    .otp_mode             (otp_mode),
    .array_access_blocked (array_access_blocked),
    .customer_lock_bit    (customer_lock_bit),
    .standby              (standby),
    .powerup_ready        (powerup_ready),
    .erased_fill          (erased_fill)
  );
  spi_host_model spi_host_model_inst (.clk(clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Watchdog against a hang.
  initial begin
    #400us;
    num_errors++;
    report_and_stop();
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic frame(input logic [23:0] v, input int n);
    spi_host_model_inst.xfer(v, n, rd);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 100 && powerup_ready !== 1'b1; i++) begin
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask
  // Reads the lock register twice in one frame and compares the second copy.
  task automatic rd_reg(input string name);
    array_busy <= 1'($urandom);
    frame(24'h2B_0000, 24);
    check(name, {6'h00, m_lock, m_fac}, rd);
    $display("Test %s done", name);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    array_busy = 1'b0;
    void'($urandom(19213));
    factory_locked = 1'($urandom);
    m_fac = factory_locked;
    d = 8'($urandom) | 8'h02;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wait_ready();
    check("state", 8'h09, {4'h0, standby, write_enable_latch, otp_mode, powerup_ready});
    check("fill", 8'hFF, erased_fill);
    rd_reg("powerup");
    frame({8'h2F, d, 8'h00}, 15);
    frame({8'h2F, d, d}, 24);
    rd_reg("boundary");
    frame(24'hB1_0000, 8);
    check("otp", {6'h00, otp_mode, array_access_blocked}, 8'h03);
    frame({8'h2F, d, 8'h00}, 16);
    frame(24'hC1_0000, 8);
    check("exit", 8'h00, {7'h00, otp_mode});
    rd_reg("otp_mode");
    frame({8'h2F, d, 8'h00}, 16);
    m_lock = 1'b1;
    rd_reg("lock");
    frame(24'h2F_0000, 16);
    rd_reg("sticky");
    frame(24'h06_0000, 8);
    check("wel_set", 8'h01, {7'h00, write_enable_latch});
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wait_ready();
    check("wel_clear", 8'h00, {7'h00, write_enable_latch});
    $display("Test reset done");
    report_and_stop();
  end
endmodule
